/* File: mrgs_adc_model.sv */
// converter model: encodes the routed channel and delays its word
`timescale 1ns/10ps
module mrgs_adc_model (
  // clock
  input wire logic core_clk,
  // switch controls from the selector
  input wire mrgs_pkg::mrgs_sw_s sw_out,
  // channel of the word leaving the converter
  output mrgs_pkg::mrgs_code_t adc_chan
);
  import mrgs_pkg::*;
  mrgs_code_t pipe_r [3];
  mrgs_code_t chan;
  // index of the routed channel
  always_comb begin
    chan = 3'h0;
    for (int i = 0; i < 8; i++) begin
      if (sw_out.mux_onehot[i]) chan = 3'(i);
    end
  end
  // encode on the rising edge, word leaves two clocks later
  always_ff @(posedge core_clk) begin
    pipe_r[0] <= chan;
    pipe_r[1] <= pipe_r[0];
    pipe_r[2] <= pipe_r[1];
  end
  assign adc_chan = pipe_r[2];
endmodule // mrgs_adc_model

/* File: mrgs_map.svh */
// constants for the multirange gain selector
`ifndef MRGS_MAP_SVH
`define MRGS_MAP_SVH
`define MRGS_CLK_MHZ 40
`define MRGS_PIPE_STAGES 3
`define MRGS_MODE_AUTO 4'h0
`define MRGS_MODE_FORCE_BIT 3
`define MRGS_MODE_MON_BIT 2
`define MRGS_CODE_X33 3'h0
`define MRGS_CODE_X9 3'h1
`define MRGS_CODE_X5 3'h2
`define MRGS_CODE_X1 3'h3
`define MRGS_CODE_MON_BIT 2
`define MRGS_THRESH_PCT 80
`define MRGS_RESET_CODE 3'h3
`define MRGS_RESET_ONEHOT 8'h08
`define MRGS_CODE_TEMP 3'h4
`define MRGS_CODE_TEMP_DUMMY 3'h5
`define MRGS_CODE_LEAK 3'h6
`define MRGS_CODE_REF 3'h7
`define MRGS_SYNC_STAGES 2
`define MRGS_SAT_RESET 3'h7
`endif

/* File: mrgs_monitor.sv */
// port checker for the range selector unit
`timescale 1ns/10ps
module mrgs_monitor #(
  parameter int PIPE_STAGES = 3
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // watched ports
  input wire mrgs_pkg::mrgs_mode_t mode_select_inputs,
  input wire mrgs_pkg::mrgs_sat_s sat_in,
  input wire mrgs_pkg::mrgs_sw_s sw_out,
  input wire mrgs_pkg::mrgs_code_t range_code_outputs
);
  import mrgs_pkg::*;
  logic [2:0] cnt_r;
  logic [7:0] mux_rise_r;
  mrgs_code_t e;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  // code the inputs call for, before sync and pipe delay
  always_comb begin
    if (mode_select_inputs[3]) e = {mode_select_inputs[2], mode_select_inputs[1:0]};
    else if (!sat_in.sat_x33) e = 3'h0;
    else if (!sat_in.sat_x9) e = 3'h1;
    else if (!sat_in.sat_x5) e = 3'h2;
    else e = 3'h3;
  end
  // edges since reset release, saturating, so $past never reaches into reset
  always_ff @(posedge core_clk) begin
    if (rst) cnt_r <= 3'h0;
    else if (cnt_r != 3'h7) cnt_r <= cnt_r + 3'h1;
  end
  // mux as seen at each rising edge, to show it did not move before the falling edge
  always_ff @(posedge core_clk) begin
    mux_rise_r <= sw_out.mux_onehot;
  end
  a_auto_pick:
    assert property (cnt_r == 3'h7 && $past(mode_select_inputs, PIPE_STAGES + 2) == 4'h0
      |-> range_code_outputs == $past(e, PIPE_STAGES + 2)) else $error("auto code wrong");
  a_forced_code:
    assert property (cnt_r == 3'h7 && $past(mode_select_inputs[3:2], PIPE_STAGES + 2) == 2'h2
      |-> range_code_outputs == $past(e, PIPE_STAGES + 2)) else $error("forced code wrong");
  a_monitor_code:
    assert property (cnt_r == 3'h7 && $past(mode_select_inputs[3:2], PIPE_STAGES + 2) == 2'h3
      |-> range_code_outputs == $past(e, PIPE_STAGES + 2)) else $error("monitor code wrong");
  a_mux_route:
    assert property (cnt_r == 3'h7 && ($past(mode_select_inputs, 2) == 4'h0
      || $past(mode_select_inputs[3], 2)) |-> sw_out.mux_onehot == (8'h01 << $past(e, 2)))
      else $error("mux route wrong");
  a_code_pipe:
    assert property (cnt_r == 3'h7 |-> (8'h01 << range_code_outputs)
      == $past(sw_out.mux_onehot, PIPE_STAGES)) else $error("code not aligned");
  a_hold_toggle:
    assert property (cnt_r != 3'h0 |-> sw_out.hold != $past(sw_out.hold))
      else $error("hold did not toggle");
  a_mux_onehot:
    assert property ($onehot(sw_out.mux_onehot)) else $error("mux not one-hot");
  a_mux_steady:
    assert property (@(negedge core_clk) cnt_r != 3'h0 |-> sw_out.mux_onehot == mux_rise_r)
      else $error("mux moved between falling edges");
  a_reset_state:
    assert property (cnt_r == 3'h0 |-> !sw_out.hold && range_code_outputs == 3'h3
      && sw_out.mux_onehot == 8'h08) else $error("reset state wrong");
endmodule // mrgs_monitor
bind mrgs_range_selector_unit mrgs_monitor #(.PIPE_STAGES(PIPE_STAGES)) u_mon (
  .core_clk(core_clk), .rst(rst), .mode_select_inputs(mode_select_inputs),
  .sat_in(sat_in), .sw_out(sw_out), .range_code_outputs(range_code_outputs));

/* File: mrgs_pipe.sv */
// delay line that aligns the range code with converter latency
`timescale 1ns/10ps
module mrgs_pipe #(
  parameter int WIDTH = 3,
  parameter int DEPTH = 3,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // data
  input wire logic [WIDTH-1:0] din,
  output logic [WIDTH-1:0] dout
);
  logic [WIDTH-1:0] stage_r [DEPTH];

  // shift one stage per clock
  always_ff @(posedge core_clk) begin
    if (rst) begin
      for (int i = 0; i < DEPTH; i++) begin
        stage_r[i] <= RST_VAL;
      end
    end else begin
      stage_r[0] <= din;
      for (int i = 1; i < DEPTH; i++) begin
        stage_r[i] <= stage_r[i-1];
      end
    end
  end

  assign dout = stage_r[DEPTH-1];
endmodule // mrgs_pipe

/* File: mrgs_pkg.sv */
// types for the multirange gain selector
package mrgs_pkg;
  typedef logic [2:0] mrgs_code_t;
  typedef logic [3:0] mrgs_mode_t;
  // one comparator per high-gain stage, high when saturated
  typedef struct packed {
    logic sat_x33;
    logic sat_x9;
    logic sat_x5;
  } mrgs_sat_s;
  // analog switch controls
  typedef struct packed {
    logic hold;
    logic [7:0] mux_onehot;
  } mrgs_sw_s;
  typedef enum logic [2:0] {
    MRGS_ST_AUTO = 3'b001,
    MRGS_ST_FORCE = 3'b010,
    MRGS_ST_MON = 3'b100
  } mrgs_state_e;
endpackage

/* File: mrgs_range_selector_unit.sv */
// range selector unit: gain choice, switch control and code pipeline
// ----------------------------------------------------------------
// ----------------------------------------------------------------
`timescale 1ns/10ps
`include "mrgs_map.svh"
module mrgs_range_selector_unit
#(
  parameter int PIPE_STAGES = `MRGS_PIPE_STAGES
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // static mode pins from the control chip
  input wire mrgs_pkg::mrgs_mode_t mode_select_inputs,
  // comparator results from the analog stages
  input wire mrgs_pkg::mrgs_sat_s sat_in,
  // analog switch controls
  output mrgs_pkg::mrgs_sw_s sw_out,
  // code aligned with converter data
  output mrgs_pkg::mrgs_code_t range_code_outputs
);
  import mrgs_pkg::*;

  // ----------------------------------------------------------------
  // input synchronisers
  // ----------------------------------------------------------------
  mrgs_mode_t mode_sync;
  mrgs_sat_s sat_sync;

  // two flops on the mode pins; they are static, so the latency is harmless
  mrgs_pipe #(
    .WIDTH($bits(mrgs_mode_t)),
    .DEPTH(`MRGS_SYNC_STAGES),
    .RST_VAL(`MRGS_MODE_AUTO)
  ) u_mode_sync (
    .core_clk(core_clk),
    .rst(rst),
    .din(mode_select_inputs), // mode is not latched further
    .dout(mode_sync)
  );

  // two flops on the comparators; reset reads as all saturated so the
  // first decision after reset stays on x1, like the reset code
  mrgs_pipe #(
    .WIDTH($bits(mrgs_sat_s)),
    .DEPTH(`MRGS_SYNC_STAGES),
    .RST_VAL(`MRGS_SAT_RESET)
  ) u_sat_sync (
    .core_clk(core_clk),
    .rst(rst),
    .din(sat_in),
    .dout(sat_sync)
  );

  // ----------------------------------------------------------------
  // mode decode
  // ----------------------------------------------------------------
  mrgs_state_e mode_st;

  // top bit clear: auto; top set, next clear: forced; both set: monitor
  // the pins are level inputs, so a change simply takes effect after sync
  always_comb begin
    if (!mode_sync[`MRGS_MODE_FORCE_BIT]) begin
      mode_st = MRGS_ST_AUTO;
    end else if (!mode_sync[`MRGS_MODE_MON_BIT]) begin
      mode_st = MRGS_ST_FORCE;
    end else begin
      mode_st = MRGS_ST_MON;
    end
  end

  // ----------------------------------------------------------------
  // forced and monitor code tables
  // ----------------------------------------------------------------
  mrgs_code_t force_code;
  mrgs_code_t mon_code;

  // low mode bits name the forced gain, highest gain first
  always_comb begin
    case (mode_sync[1:0])
      2'h0: force_code = `MRGS_CODE_X33;
      2'h1: force_code = `MRGS_CODE_X9;
      2'h2: force_code = `MRGS_CODE_X5;
      2'h3: force_code = `MRGS_CODE_X1;
      default: force_code = `MRGS_RESET_CODE;
    endcase
  end

  // low mode bits name the monitor channel
  always_comb begin
    case (mode_sync[1:0])
      2'h0: mon_code = `MRGS_CODE_TEMP;
      2'h1: mon_code = `MRGS_CODE_TEMP_DUMMY;
      2'h2: mon_code = `MRGS_CODE_LEAK;
      2'h3: mon_code = `MRGS_CODE_REF;
      default: mon_code = `MRGS_RESET_CODE;
    endcase
  end

  // ----------------------------------------------------------------
  // automatic range decision
  // ----------------------------------------------------------------
  logic [3:0] pick_oh;
  mrgs_code_t auto_code;

  // one-hot pick of the highest gain whose comparator has not tripped
  // a tripped stage hands the sample down to the next lower gain
  always_comb begin
    pick_oh[0] = !sat_sync.sat_x33;
    pick_oh[1] = sat_sync.sat_x33 && !sat_sync.sat_x9;
    pick_oh[2] = sat_sync.sat_x33 && sat_sync.sat_x9 && !sat_sync.sat_x5;
    pick_oh[3] = sat_sync.sat_x33 && sat_sync.sat_x9 && sat_sync.sat_x5;
  end

  // code of the picked stage; x1 has no comparator and is the last resort
  always_comb begin
    case (pick_oh)
      4'h1: auto_code = `MRGS_CODE_X33;
      4'h2: auto_code = `MRGS_CODE_X9;
      4'h4: auto_code = `MRGS_CODE_X5;
      4'h8: auto_code = `MRGS_CODE_X1;
      default: auto_code = `MRGS_CODE_X1;
    endcase
  end

  // ----------------------------------------------------------------
  // code select
  // ----------------------------------------------------------------
  mrgs_code_t sel_code;

  // code per mode; monitor codes have bit 2 set
  always_comb begin
    case (mode_st)
      MRGS_ST_AUTO: sel_code = auto_code;
      MRGS_ST_FORCE: sel_code = force_code;
      MRGS_ST_MON: sel_code = mon_code;
      default: sel_code = `MRGS_RESET_CODE;
    endcase
  end

  // ----------------------------------------------------------------
  // sample/hold control
  // ----------------------------------------------------------------
  logic hold_r;

  // hold toggles on each rising edge: track for one clock, hold for the next
  // a half-rate square wave; the hold switch changes state only on rising edges
  always_ff @(posedge core_clk) begin
    if (rst) begin
      hold_r <= 1'b0;
    end else begin
      hold_r <= ~hold_r;
    end
  end

  // ----------------------------------------------------------------
  // mux selection register
  // ----------------------------------------------------------------
  mrgs_code_t mux_sel_r;
  logic [7:0] mux_onehot_nxt;
  logic [7:0] mux_onehot_r;

  // one switch per channel: four gains then four monitors
  // channel order: x33, x9, x5, x1, then the four monitor channels
  always_comb begin
    case (sel_code)
      3'h0: mux_onehot_nxt = 8'h01;
      3'h1: mux_onehot_nxt = 8'h02;
      3'h2: mux_onehot_nxt = 8'h04;
      3'h3: mux_onehot_nxt = 8'h08;
      3'h4: mux_onehot_nxt = 8'h10;
      3'h5: mux_onehot_nxt = 8'h20;
      3'h6: mux_onehot_nxt = 8'h40;
      3'h7: mux_onehot_nxt = 8'h80;
      default: mux_onehot_nxt = `MRGS_RESET_ONEHOT;
    endcase
  end

  // new decision every falling edge, stable until the next one
  // the routed channel must not move while the converter encodes
  always_ff @(negedge core_clk) begin
    if (rst) begin
      mux_sel_r <= `MRGS_RESET_CODE;
      mux_onehot_r <= `MRGS_RESET_ONEHOT;
    end else begin
      mux_sel_r <= sel_code;
      mux_onehot_r <= mux_onehot_nxt;
    end
  end

  // ----------------------------------------------------------------
  // switch outputs
  // ----------------------------------------------------------------
  // both switch controls come straight from flops
  assign sw_out = '{hold: hold_r, mux_onehot: mux_onehot_r};

  // ----------------------------------------------------------------
  // code pipeline
  // ----------------------------------------------------------------
  // three rising-edge stages after the falling-edge capture
  // matches the converter latency so code and data word leave together
  mrgs_pipe #(
    .WIDTH($bits(mrgs_code_t)),
    .DEPTH(PIPE_STAGES),
    .RST_VAL(`MRGS_RESET_CODE)
  ) u_pipe (
    .core_clk(core_clk),
    .rst(rst),
    .din(mux_sel_r),
    .dout(range_code_outputs)
  );
endmodule // mrgs_range_selector_unit

/* File: tb.sv */
// testbench for the range selector unit
`timescale 1ns/10ps
module tb;
  import mrgs_pkg::*;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  mrgs_mode_t mode = 4'h0;
  mrgs_sat_s sat = 3'h0;
  mrgs_sw_s sw;
  mrgs_code_t code;
  mrgs_code_t adc_chan;
  int n_errors = 0;
  int num_checks = 0;
  always #12.5 core_clk = ~core_clk;
  mrgs_range_selector_unit u_dut (.core_clk(core_clk), .rst(rst), .mode_select_inputs(mode),
    .sat_in(sat), .sw_out(sw), .range_code_outputs(code));
  mrgs_adc_model u_adc (.core_clk(core_clk), .sw_out(sw), .adc_chan(adc_chan));
  // wait edges, then step just past the last one
  task automatic cyc(int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  task automatic chk(string what, logic [7:0] exp, logic [7:0] got);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  // drive, settle past sync and pipe, judge code, switch and converter word
  task automatic apply(mrgs_mode_t m, mrgs_sat_s s, mrgs_code_t exp);
    mode = m;
    sat = s;
    cyc(8);
    chk("code", 8'(exp), 8'(code));
    chk("mux", 8'h01 << exp, sw.mux_onehot);
    chk("adc", 8'(exp), 8'(adc_chan));
  endtask
  // comparator patterns in auto mode, then a burst changing every cycle
  task automatic t_auto();
    apply(4'h0, 3'h0, 3'h0);
    apply(4'h0, 3'h1, 3'h0);
    apply(4'h0, 3'h5, 3'h1);
    apply(4'h0, 3'h6, 3'h2);
    for (int i = 0; i < 16; i++) begin
      sat = 3'(i);
      cyc(1);
    end
    apply(4'h0, 3'h7, 3'h3);
  endtask
  // every forced range with all stages saturated, each followed by the monitor channel of the same number
  task automatic t_modes();
    for (int m = 0; m < 4; m++) begin
      apply(4'h8 | 4'(m), 3'h7, 3'(m));
      apply(4'hC | 4'(m), 3'h0, 3'h4 | 3'(m));
    end
  endtask
  // reset in mid-run returns to x1, then auto resumes
  task automatic t_reset();
    rst = 1'b1;
    cyc(2);
    chk("rst code", 8'h03, 8'(code));
    chk("rst mux", 8'h08, sw.mux_onehot);
    rst = 1'b0;
    apply(4'h0, 3'h4, 3'h1);
  endtask
  task automatic results();
    if (n_errors == 0 && num_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  initial begin
    cyc(16);
    rst = 1'b0;
    t_auto();
    t_modes();
    t_reset();
    results();
  end
endmodule // tb
